// ---- baud_tick.sv ----
`timescale 1ns/1ps
module baud_tick (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // divisor
  input wire logic [11:0] divisor,
  input wire logic reload,
  // oversample enable
  output logic tick
);
  import uart_pkg::*;

  logic [11:0] cnt_r;

  assign tick = cnt_r == 12'h000 && !reload;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 12'h000;
    end else if (reload || cnt_r == 12'h000) begin
      cnt_r <= divisor;
    end else begin
      cnt_r <= cnt_r - 12'h001;
    end
  end
endmodule : baud_tick

// ---- rx_fifo.sv ----
`timescale 1ns/1ps
`include "uart_defines.svh"
module rx_fifo (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // fill side
  input wire logic flush,
  input wire logic push,
  input wire uart_pkg::rx_entry_t push_data,
  // drain side
  input wire logic pop,
  output uart_pkg::rx_entry_t head,
  output logic empty,
  output logic full
);
  import uart_pkg::*;

  logic [1:0] count_r;
  rx_entry_t head_r;
  rx_entry_t tail_r;
  logic do_pop;
  logic do_push;

  assign empty = count_r == 2'h0;
  assign full = count_r == `RX_DEPTH;
  assign do_pop = pop && !empty;
  assign do_push = push && (!full || do_pop);
  assign head = head_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_r <= 2'h0;
    end else if (flush) begin
      count_r <= 2'h0;
    end else begin
      count_r <= count_r + {1'b0, do_push} - {1'b0, do_pop};
    end
  end

  // front entry sits in a register so the bus reads a flop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      head_r <= '0;
      tail_r <= '0;
    end else begin
      if (do_push && (empty || (count_r == 2'h1 && do_pop))) head_r <= push_data;
      else if (do_pop) head_r <= tail_r;
      if (do_push && ((count_r == 2'h1 && !do_pop) || full)) tail_r <= push_data;
    end
  end
endmodule : rx_fifo

// ---- serial_station.sv ----
`timescale 1ns/1ps
module serial_station (
  // clock
  input wire logic clk,
  // line from the device
  input wire logic txd,
  input wire logic txd_oe,
  // line into the device
  output logic rxd
);
  int bit_clks = 16;
  int nb = 8;
  int got_cnt = 0;
  logic [8:0] got = 9'h000;

  task automatic bit_wait(input int n);
    repeat (n) @(negedge clk);
  endtask : bit_wait

  // start, data lsb first, optional parity, one stop
  task automatic send(input logic [8:0] d, input int n, input logic [1:0] pm, input logic bad, input logic stp);
    logic p;
    p = pm[0] ^ bad;
    rxd = 1'b0;
    bit_wait(bit_clks);
    for (int i = 0; i < n; i++) begin
      rxd = d[i];
      p = p ^ d[i];
      bit_wait(bit_clks);
    end
    if (pm[1]) begin
      rxd = p;
      bit_wait(bit_clks);
    end
    rxd = stp;
    bit_wait(bit_clks);
    // idle high between frames, as the line pull-up would leave it
    rxd = 1'b1;
    bit_wait(2 * bit_clks);
  endtask : send

  initial begin
    rxd = 1'b1;
    forever begin
      @(negedge txd);
      if (txd_oe) begin
        logic [8:0] v;
        v = 9'h000;
        bit_wait(bit_clks / 2);
        for (int i = 0; i < nb; i++) begin
          bit_wait(bit_clks);
          v[i] = txd;
        end
        // land mid stop so a parity bit never looks like a start
        bit_wait(bit_clks);
        got = v;
        got_cnt++;
      end
    end
  end
endmodule : serial_station

// ---- tb_uart_regs.sv ----
`timescale 1ns/1ps
`include "uart_defines.svh"
module tb_uart_regs;
  import uart_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  io_req_t io_req = '0;
  logic [7:0] io_rdata;
  logic global_irq_en = 1'b0;
  logic txc_irq_ack = 1'b0;
  irq_t irq;
  logic rxd, txd, txd_oe, rxd_owned;
  int mismatches = 0;
  int checks = 0;
  int gc = 0;
  int n;
  logic [2:0] code;
  logic [8:0] m;

  always #2.5 clk = ~clk;

  uart_regs uart_regs_i (.clk(clk), .rst_b(rst_b), .io_req(io_req), .io_rdata(io_rdata),
    .global_irq_en(global_irq_en), .txc_irq_ack(txc_irq_ack), .irq(irq), .rxd(rxd), .txd(txd),
    .txd_oe(txd_oe), .rxd_owned(rxd_owned));
  serial_station serial_station_i (.clk(clk), .txd(txd), .txd_oe(txd_oe), .rxd(rxd));

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    io_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge clk);
    io_req.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] msk, input logic [7:0] e);
    @(negedge clk);
    io_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge clk);
    io_req.rd = 1'b0;
    chk({1'b0, io_rdata & msk}, {1'b0, e});
  endtask : rd

  // two reads on consecutive cycles, kept unbroken
  task automatic rd_shared(input logic [7:0] eh, input logic [7:0] ec);
    @(negedge clk);
    io_req = '{rd: 1'b1, wr: 1'b0, addr: `LOC_SHARED, wdata: 8'h00};
    @(negedge clk);
    chk({1'b0, io_rdata}, {1'b0, eh});
    @(negedge clk);
    io_req.rd = 1'b0;
    chk({1'b0, io_rdata}, {1'b0, ec});
  endtask : rd_shared

  task automatic got_wait(input logic [8:0] e);
    for (int k = 0; k < 4000 && serial_station_i.got_cnt == gc; k++) @(negedge clk);
    chk({8'h00, serial_station_i.got_cnt != gc}, 9'h001);
    gc = serial_station_i.got_cnt;
    chk(serial_station_i.got, e);
  endtask : got_wait

  task automatic snd(input logic [8:0] d, input int k);
    serial_station_i.send(d, k, 2'b00, 1'b0, 1'b1);
  endtask : snd

  task automatic complete_run;
    if (mismatches == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    complete_run();
  end

  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    rd(`LOC_STATUS_A, 8'hff, 8'h20);
    rd(`LOC_CONTROL_B, 8'hff, 8'h00);
    rd_shared(8'h00, 8'h86);
    rd(3'h5, 8'hff, 8'h00);
    wr(`LOC_SHARED, 8'h03);
    wr(`LOC_SHARED, 8'h8e);
    rd_shared(8'h03, 8'h8e);
    rd(`LOC_SHARED, 8'hff, 8'h03);
    wr(`LOC_SHARED, 8'h00);
    wr(`LOC_SHARED, 8'h86);
    // reload the prescaler so the long divisor does not linger
    wr(`LOC_BAUD_LOW, 8'h00);
    wr(`LOC_CONTROL_B, 8'h10);
    wr(`LOC_DATA, 8'h11);
    wr(`LOC_DATA, 8'h22);
    rd(`LOC_STATUS_A, 8'hff, 8'h00);
    wr(`LOC_CONTROL_B, 8'h18);
    repeat (4) @(negedge clk);
    rd(`LOC_STATUS_A, 8'h20, 8'h20);
    wr(`LOC_DATA, 8'h44);
    wr(`LOC_CONTROL_B, 8'h10);
    chk({8'h00, txd_oe}, 9'h001);
    got_wait(9'h011);
    got_wait(9'h044);
    repeat (40) @(negedge clk);
    chk({7'h00, txd_oe, txd}, 9'h001);
    rd(`LOC_STATUS_A, 8'h60, 8'h60);
    wr(`LOC_CONTROL_B, 8'h50);
    chk({6'h00, irq}, 9'h000);
    global_irq_en = 1'b1;
    @(negedge clk);
    chk({6'h00, irq}, 9'h002);
    txc_irq_ack = 1'b1;
    @(negedge clk);
    txc_irq_ack = 1'b0;
    @(negedge clk);
    chk({6'h00, irq}, 9'h000);
    wr(`LOC_CONTROL_B, 8'h30);
    chk({6'h00, irq}, 9'h001);
    wr(`LOC_CONTROL_B, 8'h90);
    snd(9'h066, 8);
    chk({6'h00, irq}, 9'h004);
    rd(`LOC_DATA, 8'hff, 8'h66);
    chk({6'h00, irq}, 9'h000);
    global_irq_en = 1'b0;
    wr(`LOC_CONTROL_B, 8'h10);
    chk({8'h00, rxd_owned}, 9'h001);
    for (int k = 1; k < 5; k++) snd(9'(k), 8);
    rd(`LOC_STATUS_A, 8'h88, 8'h88);
    rd(`LOC_DATA, 8'hff, 8'h01);
    rd(`LOC_STATUS_A, 8'h08, 8'h00);
    rd(`LOC_DATA, 8'hff, 8'h02);
    wr(`LOC_CONTROL_B, 8'h00);
    rd(`LOC_STATUS_A, 8'h9c, 8'h00);
    chk({8'h00, rxd_owned}, 9'h000);
    wr(`LOC_CONTROL_B, 8'h10);
    serial_station_i.send(9'h012, 8, 2'b00, 1'b0, 1'b0);
    rd(`LOC_STATUS_A, 8'h90, 8'h90);
    rd(`LOC_DATA, 8'hff, 8'h12);
    rd(`LOC_STATUS_A, 8'h10, 8'h00);
    // a low stop bit may start a stray frame; flush it
    wr(`LOC_CONTROL_B, 8'h00);
    wr(`LOC_CONTROL_B, 8'h10);
    for (int k = 2; k < 4; k++) begin
      wr(`LOC_SHARED, 8'h86 | 8'(k << 4));
      serial_station_i.send(9'h034, 8, 2'(k), 1'b1, 1'b1);
      rd(`LOC_STATUS_A, 8'h84, 8'h84);
      rd(`LOC_DATA, 8'hff, 8'h34);
      serial_station_i.send(9'h034, 8, 2'(k), 1'b0, 1'b1);
      rd(`LOC_STATUS_A, 8'h84, 8'h80);
      rd(`LOC_DATA, 8'hff, 8'h34);
      // parity bit rides in as a ninth sampled bit
      serial_station_i.nb = 9;
      wr(`LOC_CONTROL_B, 8'h18);
      wr(`LOC_DATA, 8'h34);
      got_wait({k == 2, 8'h34});
    end
    for (int k = 0; k < 5; k++) begin
      code = (k < 4) ? 3'(k) : 3'h7;
      n = (k < 4) ? k + 5 : 9;
      m = 9'h1ff >> (9 - n);
      serial_station_i.nb = n;
      wr(`LOC_SHARED, {5'b10000, code[1:0], 1'b0});
      wr(`LOC_CONTROL_B, {5'b00011, code[2], 2'b01});
      wr(`LOC_DATA, 8'ha5);
      got_wait(9'h1a5 & m);
      snd(9'h15a, n);
      if (n == 9) rd(`LOC_CONTROL_B, 8'h02, 8'h02);
      rd(`LOC_DATA, 8'hff, 8'h5a & m[7:0]);
    end
    rd(`LOC_STATUS_A, 8'h40, 8'h40);
    wr(`LOC_STATUS_A, 8'h41);
    rd(`LOC_STATUS_A, 8'h41, 8'h01);
    snd(9'h044, 9);
    snd(9'h1bb, 9);
    rd(`LOC_CONTROL_B, 8'h02, 8'h02);
    rd(`LOC_DATA, 8'hff, 8'hbb);
    rd(`LOC_STATUS_A, 8'h81, 8'h01);
    wr(`LOC_STATUS_A, 8'h02);
    wr(`LOC_SHARED, 8'h86);
    wr(`LOC_CONTROL_B, 8'h18);
    serial_station_i.bit_clks = 8;
    serial_station_i.nb = 8;
    wr(`LOC_DATA, 8'h5c);
    got_wait(9'h05c);
    snd(9'h03a, 8);
    rd(`LOC_DATA, 8'hff, 8'h3a);
    rd(`LOC_STATUS_A, 8'h03, 8'h02);
    complete_run();
  end
endmodule : tb_uart_regs

// ---- uart_defines.svh ----
`ifndef UART_DEFINES_SVH
`define UART_DEFINES_SVH
// i/o locations
`define LOC_DATA 3'h0
`define LOC_STATUS_A 3'h1
`define LOC_CONTROL_B 3'h2
`define LOC_BAUD_LOW 3'h3
`define LOC_SHARED 3'h4
// reset values and control b write mask
`define STATUS_A_RESET 8'h20
`define CTRL_B_RESET 8'h00
`define CTRL_C_RESET 8'h86
`define BAUD_RESET 12'h000
`define CTRL_B_WMASK 8'hfd
// status a bits
`define B_RXC 7
`define B_TXC 6
`define B_U2X 1
`define B_MULTIPROC_FILTER 0
// control b bits
`define B_RX_COMPLETE_IRQ_EN 7
`define B_TX_COMPLETE_IRQ_EN 6
`define B_BUFFER_EMPTY_IRQ_EN 5
`define B_RECEIVER_ON 4
`define B_TRANSMITTER_ON 3
`define B_CSZ_TOP 2
`define B_TX9 0
// control c bits
`define C_SEL 7
`define C_SYNC 6
`define C_PM_HI 5
`define C_PM_LO 4
`define C_STOP2 3
`define C_CSZ 2:1
`define C_LOW7 6:0
// baud fields
`define BAUD_HI 11:8
`define BAUD_LO 7:0
`define LOW_NIB 3:0
// timing and sizes
`define OVS_NORMAL 5'h10
`define OVS_DOUBLE 5'h08
`define NINE_BITS 4'h9
`define RX_DEPTH 2'h2
`endif

// ---- uart_pkg.sv ----
package uart_pkg;
`include "uart_defines.svh"

  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } io_req_t;

  typedef struct packed {
    logic fe;
    logic pe;
    logic [8:0] data;
  } rx_entry_t;

  typedef struct packed {
    logic rx_done;
    logic tx_done;
    logic tx_empty;
  } irq_t;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_t;

  function automatic logic [3:0] char_bits(input logic [2:0] code);
    case (code)
      3'h0: char_bits = 4'h5;
      3'h1: char_bits = 4'h6;
      3'h2: char_bits = 4'h7;
      3'h7: char_bits = 4'h9;
      default: char_bits = 4'h8;
    endcase
  endfunction : char_bits

  function automatic logic [8:0] data_mask(input logic [3:0] n);
    data_mask = 9'h1ff >> (4'h9 - n);
  endfunction : data_mask
endpackage : uart_pkg

// ---- uart_regs.sv ----
`timescale 1ns/1ps
`include "uart_defines.svh"
// What this block does
// RULE_01 - back-to-back shared read returns control C
// RULE_02 - data writes fill tx buffer, reads rx
// RULE_03 - short characters: upper bits ignored, read zero
// RULE_04 - data write while buffer full is dropped
// RULE_05 - buffered data loads when shifter empty
// RULE_06 - two-entry rx fifo advances per access
// RULE_07 - rx complete shows unread data; disable flushes
// RULE_08 - tx complete sets at end, write-one clears
// RULE_09 - buffer empty flag, set after reset
// RULE_10 - frame error follows head entry stop bit
// RULE_11 - overrun on start while fifo, shifter full
// RULE_12 - parity error only when checking was enabled
// RULE_13 - software writes zero to error bits
// RULE_14 - double speed halves oversampling, async only
// RULE_15 - multiprocessor filter drops non-address frames
// RULE_16 - interrupt needs enable, global enable, flag
// RULE_17 - receiver owns rx pin; disable flushes
// RULE_18 - tx disable waits until all data sent
// RULE_19 - three size bits select data bits
// RULE_20 - software reads ninth bit before data
// RULE_21 - software writes ninth bit before data
// RULE_22 - software keeps control C read atomic
// RULE_23 - shared write top bit picks target
// RULE_24 - size codes five to nine bits
// RULE_25 - parity codes disabled, even, odd
module uart_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // cpu i/o bus
  input wire uart_pkg::io_req_t io_req,
  output logic [7:0] io_rdata,
  // interrupt control
  input wire logic global_irq_en,
  input wire logic txc_irq_ack,
  output uart_pkg::irq_t irq,
  // serial pins
  input wire logic rxd,
  output logic txd,
  output logic txd_oe,
  output logic rxd_owned
);
  import uart_pkg::*;

  logic [7:0] ctrl_b_r, ctrl_c_r, rdata_r;
  logic [11:0] baud_r;
  logic txc_r, u2x_r, multiproc_filter_r, dor_r, prev_shared_r, reload_r;

  // bus decode
  logic rd_data, rd_stat, rd_ctl_b, rd_shared, rd_low;
  logic wr_data, wr_stat, wr_ctl_b, wr_shared, wr_low;
  assign rd_data = io_req.rd && io_req.addr == `LOC_DATA;
  assign rd_stat = io_req.rd && io_req.addr == `LOC_STATUS_A;
  assign rd_ctl_b = io_req.rd && io_req.addr == `LOC_CONTROL_B;
  assign rd_shared = io_req.rd && io_req.addr == `LOC_SHARED;
  assign rd_low = io_req.rd && io_req.addr == `LOC_BAUD_LOW;
  assign wr_data = io_req.wr && io_req.addr == `LOC_DATA;
  assign wr_stat = io_req.wr && io_req.addr == `LOC_STATUS_A;
  assign wr_ctl_b = io_req.wr && io_req.addr == `LOC_CONTROL_B;
  assign wr_shared = io_req.wr && io_req.addr == `LOC_SHARED;
  assign wr_low = io_req.wr && io_req.addr == `LOC_BAUD_LOW;

  // frame format
  logic [3:0] nbits;
  logic [8:0] mask;
  logic [4:0] ovs;
  logic par_en, par_odd, stop2, tick, receiver_on, transmitter_on;
  assign nbits = char_bits({ctrl_b_r[`B_CSZ_TOP], ctrl_c_r[`C_CSZ]}); // RULE_19 RULE_24
  assign mask = data_mask(nbits);
  assign par_en = ctrl_c_r[`C_PM_HI]; // RULE_25
  assign par_odd = ctrl_c_r[`C_PM_LO];
  assign stop2 = ctrl_c_r[`C_STOP2];
  // sync mode ignores double speed
  assign ovs = (u2x_r && !ctrl_c_r[`C_SYNC]) ? `OVS_DOUBLE : `OVS_NORMAL; // RULE_14
  assign receiver_on = ctrl_b_r[`B_RECEIVER_ON];
  assign transmitter_on = ctrl_b_r[`B_TRANSMITTER_ON];

  // prescaler restarts the cycle after the low byte lands
  baud_tick u_baud (
    .clk(clk),
    .rst_b(rst_b),
    .divisor(baud_r),
    .reload(reload_r),
    .tick(tick)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_b_r <= `CTRL_B_RESET;
      ctrl_c_r <= `CTRL_C_RESET;
      baud_r <= `BAUD_RESET;
      u2x_r <= 1'b0;
      multiproc_filter_r <= 1'b0;
      reload_r <= 1'b0;
      prev_shared_r <= 1'b0;
    end else begin
      if (wr_ctl_b) ctrl_b_r <= io_req.wdata & `CTRL_B_WMASK;
      if (wr_shared && io_req.wdata[`C_SEL]) ctrl_c_r <= io_req.wdata; // RULE_23
      if (wr_shared && !io_req.wdata[`C_SEL]) baud_r[`BAUD_HI] <= io_req.wdata[`LOW_NIB]; // RULE_23
      if (wr_low) baud_r[`BAUD_LO] <= io_req.wdata;
      if (wr_stat) u2x_r <= io_req.wdata[`B_U2X];
      if (wr_stat) multiproc_filter_r <= io_req.wdata[`B_MULTIPROC_FILTER];
      reload_r <= wr_low;
      prev_shared_r <= rd_shared; // RULE_01
    end
  end

  // transmitter
  logic [8:0] tx_buf_r;
  logic [12:0] tx_sh_r;
  logic [3:0] tx_left_r, tx_len;
  logic [4:0] tx_ovs_r;
  logic tx_full_r, tx_owned_r, txd_r, tx_busy, tx_bit_end, tx_load, tx_last, tx_accept;
  assign tx_busy = tx_left_r != 4'h0;
  assign tx_bit_end = tick && tx_ovs_r == ovs - 5'h01;
  assign tx_load = tx_owned_r && tx_full_r && !tx_busy; // RULE_05
  assign tx_last = tx_busy && tx_bit_end && tx_left_r == 4'h1;
  assign tx_accept = wr_data && !tx_full_r; // RULE_04
  assign tx_len = 4'h2 + nbits + {3'h0, par_en} + {3'h0, stop2};

  // start bit at bit 0, idle ones fill the top
  function automatic logic [12:0] build_frame(input logic [8:0] d, input logic [3:0] n);
    logic [12:0] f;
    f = 13'h1ffe;
    for (int i = 0; i < 9; i++) begin
      if (i < n) f[i + 1] = d[i];
    end
    if (par_en) f[n + 1] = par_odd ^ (^d);
    build_frame = f;
  endfunction : build_frame

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_buf_r <= 9'h000;
      tx_full_r <= 1'b0;
    end else begin
      if (tx_accept) tx_buf_r <= {ctrl_b_r[`B_TX9], io_req.wdata} & mask; // RULE_02 RULE_03
      if (tx_accept) tx_full_r <= 1'b1;
      else if (tx_load) tx_full_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_sh_r <= 13'h1fff;
      tx_left_r <= 4'h0;
      tx_ovs_r <= 5'h00;
    end else if (tx_load) begin
      tx_sh_r <= build_frame(tx_buf_r, nbits); // RULE_05
      tx_left_r <= tx_len;
      tx_ovs_r <= 5'h00;
    end else if (tx_bit_end && tx_busy) begin
      tx_sh_r <= {1'b1, tx_sh_r[12:1]};
      tx_left_r <= tx_left_r - 4'h1;
      tx_ovs_r <= 5'h00;
    end else if (tick && tx_busy) begin
      tx_ovs_r <= tx_ovs_r + 5'h01;
    end
  end

  // pin stays owned until shifter and buffer drain
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_owned_r <= 1'b0;
      txd_r <= 1'b1;
    end else begin
      tx_owned_r <= transmitter_on || (tx_owned_r && (tx_busy || tx_full_r)); // RULE_18
      txd_r <= tx_busy ? tx_sh_r[0] : 1'b1;
    end
  end

  // set wins over both clears
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txc_r <= 1'b0;
    end else if (tx_last && !tx_full_r) begin
      txc_r <= 1'b1; // RULE_08
    end else if ((wr_stat && io_req.wdata[`B_TXC]) || txc_irq_ack) begin
      txc_r <= 1'b0; // RULE_08
    end
  end

  // receive pin: three flops, change taken when last two agree
  logic rx_s1_r, rx_s2_r, rx_s3_r, rx_lvl_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_s3_r <= 1'b1;
      rx_lvl_r <= 1'b1;
    end else begin
      rx_s1_r <= rxd;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
      if (rx_s2_r == rx_s3_r) rx_lvl_r <= rx_s3_r;
    end
  end

  // receiver
  rx_state_t rx_state_r;
  logic [4:0] rx_ovs_r;
  logic [3:0] rx_cnt_r, rx_need;
  logic [10:0] rx_bits_r, rx_frame;
  rx_entry_t rx_wait_r, rx_new, head;
  logic rx_wait_v_r, rx_mid, rx_done, rx_stop, rx_addr, rx_keep, rx_start;
  logic fifo_empty, fifo_full, rx_push, overrun;
  assign rx_need = nbits + {3'h0, par_en} + 4'h1;
  assign rx_mid = tick && rx_ovs_r == ovs - 5'h01;
  assign rx_done = rx_state_r == RX_BITS && rx_mid && rx_cnt_r == rx_need - 4'h1;
  assign rx_start = rx_state_r == RX_IDLE && receiver_on && !rx_lvl_r;

  always_comb begin
    rx_frame = rx_bits_r;
    rx_frame[rx_cnt_r] = rx_lvl_r;
  end

  assign rx_stop = rx_frame[4'(nbits + {3'h0, par_en})];
  assign rx_new.data = rx_frame[8:0] & mask; // RULE_03
  assign rx_new.fe = !rx_stop; // RULE_10
  assign rx_new.pe = par_en && ((par_odd ^ (^rx_new.data)) != rx_frame[nbits]); // RULE_12
  assign rx_addr = nbits == `NINE_BITS ? rx_frame[8] : rx_stop;
  assign rx_keep = rx_done && !(multiproc_filter_r && !rx_addr) && !rx_wait_v_r; // RULE_15
  // a held character goes first so order is kept
  assign rx_push = (rx_wait_v_r || rx_keep) && !fifo_full;
  assign overrun = rx_start && fifo_full && rx_wait_v_r; // RULE_11

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_state_r <= RX_IDLE;
      rx_ovs_r <= 5'h00;
      rx_cnt_r <= 4'h0;
      rx_bits_r <= 11'h000;
    end else if (!receiver_on) begin
      rx_state_r <= RX_IDLE;
    end else begin
      case (rx_state_r)
        RX_IDLE: begin
          rx_ovs_r <= 5'h00;
          if (!rx_lvl_r) rx_state_r <= RX_START;
        end
        RX_START: begin
          if (tick && rx_ovs_r == (ovs >> 1) - 5'h01) begin
            rx_state_r <= rx_lvl_r ? RX_IDLE : RX_BITS;
            rx_ovs_r <= 5'h00;
            rx_cnt_r <= 4'h0;
            rx_bits_r <= 11'h000;
          end else if (tick) begin
            rx_ovs_r <= rx_ovs_r + 5'h01;
          end
        end
        RX_BITS: begin
          if (rx_mid) begin
            rx_bits_r <= rx_frame;
            rx_ovs_r <= 5'h00;
            rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_done) rx_state_r <= RX_IDLE;
          end else if (tick) begin
            rx_ovs_r <= rx_ovs_r + 5'h01;
          end
        end
        default: rx_state_r <= RX_IDLE;
      endcase
    end
  end

  // character held in the shifter while the fifo is full
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_wait_r <= '0;
      rx_wait_v_r <= 1'b0;
    end else if (!receiver_on) begin
      rx_wait_v_r <= 1'b0;
    end else if (rx_keep && fifo_full) begin
      rx_wait_r <= rx_new;
      rx_wait_v_r <= 1'b1;
    end else if (rx_push) begin
      rx_wait_v_r <= 1'b0;
    end
  end

  rx_fifo u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .flush(!receiver_on), // RULE_07 RULE_17
    .push(rx_push),
    .push_data(rx_wait_v_r ? rx_wait_r : rx_new),
    .pop(rd_data), // RULE_06
    .head(head),
    .empty(fifo_empty),
    .full(fifo_full)
  );

  // overrun set wins over the clear by a data read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dor_r <= 1'b0;
    end else if (!receiver_on) begin
      dor_r <= 1'b0; // RULE_17
    end else if (overrun) begin
      dor_r <= 1'b1; // RULE_11
    end else if (rd_data) begin
      dor_r <= 1'b0;
    end
  end

  // read side
  logic rx_complete_flag, tx_buffer_empty_flag;
  logic [7:0] stat_a, ctl_b_view, shared_view, rd_mux;
  assign rx_complete_flag = !fifo_empty; // RULE_07
  assign tx_buffer_empty_flag = !tx_full_r; // RULE_09
  assign stat_a = {rx_complete_flag, txc_r, tx_buffer_empty_flag, head.fe && rx_complete_flag, dor_r, head.pe && rx_complete_flag, u2x_r, multiproc_filter_r}; // RULE_10 RULE_12
  assign ctl_b_view = {ctrl_b_r[7:2], head.data[8], ctrl_b_r[`B_TX9]};
  assign shared_view = prev_shared_r ? {1'b1, ctrl_c_r[`C_LOW7]} : {4'h0, baud_r[`BAUD_HI]}; // RULE_01
  assign rd_mux = rd_data ? head.data[7:0] // RULE_02
                : rd_stat ? stat_a
                : rd_ctl_b ? ctl_b_view
                : rd_shared ? shared_view
                : rd_low ? baud_r[`BAUD_LO]
                : 8'h00;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
    end else if (io_req.rd) begin
      rdata_r <= rd_mux;
    end
  end

  assign io_rdata = rdata_r;
  assign irq = {ctrl_b_r[`B_RX_COMPLETE_IRQ_EN] && global_irq_en && rx_complete_flag, // RULE_16
                ctrl_b_r[`B_TX_COMPLETE_IRQ_EN] && global_irq_en && txc_r,
                ctrl_b_r[`B_BUFFER_EMPTY_IRQ_EN] && global_irq_en && tx_buffer_empty_flag};
  assign txd = tx_owned_r ? txd_r : 1'b1;
  assign txd_oe = tx_owned_r; // RULE_18
  assign rxd_owned = receiver_on; // RULE_17

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  shared_second_a: assert property (rd_shared && prev_shared_r |=> io_rdata == {1'b1, $past(ctrl_c_r[6:0])}) // RULE_01
    else $error("second shared read did not return control C");
  shared_first_a: assert property (rd_shared && !prev_shared_r |=> io_rdata[7:4] == 4'h0) // RULE_01
    else $error("first shared read did not return baud high");
  full_drop_a: assert property (wr_data && tx_full_r && !tx_load |=> $stable(tx_buf_r)) // RULE_04
    else $error("write to full tx buffer changed it");
  short_read_a: assert property (rd_data |=> (io_rdata & ~$past(mask[7:0])) == 8'h00) // RULE_03
    else $error("unused upper data bits read nonzero");
  txc_set_a: assert property (tx_last && !tx_full_r |=> txc_r && !tx_busy) // RULE_08
    else $error("tx complete not set after last bit");
  flush_off_a: assert property (!receiver_on |=> !rx_complete_flag && !dor_r) // RULE_07
    else $error("disabled receiver kept data or overrun");
  tx_drain_a: assert property (!transmitter_on && tx_owned_r && (tx_busy || tx_full_r) |=> txd_oe) // RULE_18
    else $error("tx pin released with data pending");
  filter_drop_a: assert property (rx_done && multiproc_filter_r && !rx_addr && !rx_wait_v_r |-> !rx_push) // RULE_15
    else $error("data frame kept under multiprocessor filter");
  irq_gate_a: assert property (irq.rx_done |-> global_irq_en && ctrl_b_r[`B_RX_COMPLETE_IRQ_EN] && !fifo_empty) // RULE_16
    else $error("rx interrupt without all enables");
  baud_hi_a: assert property (wr_shared && !io_req.wdata[7] |=> baud_r[11:8] == $past(io_req.wdata[3:0])) // RULE_23
    else $error("baud high byte not written");

  tx_frame_c: cover property (tx_last);
  rx_push_c: cover property (rx_push && rx_keep);
  overrun_c: cover property (overrun);
  ctrl_c_read_c: cover property (rd_shared && prev_shared_r);
endmodule : uart_regs
